// ---- rtl/rxs_pkg.sv ----
package rxs_pkg;

  localparam int CLK_MHZ       = 100;
  localparam int WORD_W        = 32;
  localparam int SER_HALF_CYC  = 5;
  localparam int WAIT_W        = 20;

  localparam int WAIT_LE_US    = 10;
  localparam int WAIT_VCO_US   = 1200;
  localparam int WAIT_AMP_US   = 500;
  localparam int WAIT_LOCK_US  = 100;
  localparam int CYC_LE        = WAIT_LE_US * CLK_MHZ;
  localparam int CYC_VCO       = WAIT_VCO_US * CLK_MHZ;
  localparam int CYC_AMP       = WAIT_AMP_US * CLK_MHZ;
  localparam int CYC_LOCK      = WAIT_LOCK_US * CLK_MHZ;

  localparam logic [2:0] W_NONE = 3'h0;
  localparam logic [2:0] W_LE   = 3'h1;
  localparam logic [2:0] W_VCO  = 3'h2;
  localparam logic [2:0] W_AMP  = 3'h3;
  localparam logic [2:0] W_LOCK = 3'h4;

  localparam logic [6:0] INIT_FIRST  = 7'h00;
  localparam logic [6:0] RECAL_FIRST = 7'h29;

  localparam int TEMP_DELTA_C = 10;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TEMP   = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0C;

  localparam int CTRL_INIT_GO  = 0;
  localparam int CTRL_RECAL_GO = 1;
  localparam int CTRL_AUTO_EN  = 2;
  localparam logic CTRL_AUTO_RST = 1'b0;

  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_RECAL   = 2;
  localparam int STAT_PENDING = 3;
  localparam int STAT_IDX_LSB = 8;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'h0,
    SQ_SEND = 2'h1,
    SQ_XFER = 2'h3,
    SQ_HOLD = 2'h2
  } rxs_seq_st_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'h0,
    SR_LOW  = 2'h1,
    SR_HIGH = 2'h3,
    SR_LE   = 2'h2
  } rxs_ser_st_t;

endpackage : rxs_pkg

// ---- rtl/rxs_link_if.sv ----
`timescale 1ns/1ns
interface rxs_link_if;
  logic                        spi_start;
  logic [rxs_pkg::WORD_W-1:0]  spi_word;
  logic                        spi_done;
  logic                        spi_busy;
  logic                        tmr_start;
  logic [rxs_pkg::WAIT_W-1:0]  tmr_count;
  logic                        tmr_done;

  modport seq (output spi_start, output spi_word, input spi_done, input spi_busy,
               output tmr_start, output tmr_count, input tmr_done);
  modport ser (input spi_start, input spi_word, output spi_done, output spi_busy);
  modport tmr (input tmr_start, input tmr_count, output tmr_done);
endinterface : rxs_link_if

// ---- rtl/rxs_ser_shift.sv ----
`timescale 1ns/1ns
module rxs_ser_shift #(
  parameter int HALF = rxs_pkg::SER_HALF_CYC
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  rxs_link_if.ser     lnk,
  output logic        sclk_o,
  output logic        sdata_o,
  output logic        le_o
);
  localparam int CW = $clog2(HALF + 1);

  rxs_pkg::rxs_ser_st_t        st;
  logic [CW-1:0]               cnt;
  logic [4:0]                  bits;
  logic [rxs_pkg::WORD_W-1:0]  shreg;
  logic                        half_end;

  assign half_end     = (cnt == CW'(HALF - 1));
  assign lnk.spi_busy = (st != rxs_pkg::SR_IDLE);

  // data changes on the falling edge, so it is stable a full half period before the rising edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st           <= rxs_pkg::SR_IDLE;
      cnt          <= '0;
      bits         <= 5'h00;
      shreg        <= '0;
      sclk_o       <= 1'b0;
      sdata_o      <= 1'b0;
      le_o         <= 1'b0;
      lnk.spi_done <= 1'b0;
    end
    else
    begin
      lnk.spi_done <= 1'b0;
      case (st)
        rxs_pkg::SR_IDLE:
        begin
          cnt <= '0;
          if (lnk.spi_start)
          begin
            shreg   <= lnk.spi_word;
            sdata_o <= lnk.spi_word[rxs_pkg::WORD_W-1];
            bits    <= 5'h1F;
            st      <= rxs_pkg::SR_LOW;
          end
        end
        rxs_pkg::SR_LOW:
        begin
          cnt <= half_end ? '0 : cnt + CW'(1);
          if (half_end)
          begin
            sclk_o <= 1'b1;
            st     <= rxs_pkg::SR_HIGH;
          end
        end
        rxs_pkg::SR_HIGH:
        begin
          cnt <= half_end ? '0 : cnt + CW'(1);
          if (half_end)
          begin
            sclk_o <= 1'b0;
            if (bits == 5'h00)
            begin
              le_o <= 1'b1;
              st   <= rxs_pkg::SR_LE;
            end
            else
            begin
              bits    <= bits - 5'h01;
              shreg   <= {shreg[rxs_pkg::WORD_W-2:0], 1'b0};
              sdata_o <= shreg[rxs_pkg::WORD_W-2];
              st      <= rxs_pkg::SR_LOW;
            end
          end
        end
        rxs_pkg::SR_LE:
        begin
          cnt <= half_end ? '0 : cnt + CW'(1);
          if (half_end)
          begin
            le_o         <= 1'b0;
            sdata_o      <= 1'b0;
            lnk.spi_done <= 1'b1;
            st           <= rxs_pkg::SR_IDLE;
          end
        end
        default:
        begin
          st <= rxs_pkg::SR_IDLE;
        end
      endcase
    end
  end
endmodule : rxs_ser_shift

// ---- rtl/rxs_wait_timer.sv ----
`timescale 1ns/1ns
module rxs_wait_timer (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  rxs_link_if.tmr     lnk
);
  logic [rxs_pkg::WAIT_W-1:0] cnt;
  logic                       run;

  // a count of zero is treated as one cycle, never as a free-running wait
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt          <= '0;
      run          <= 1'b0;
      lnk.tmr_done <= 1'b0;
    end
    else
    begin
      lnk.tmr_done <= 1'b0;
      if (lnk.tmr_start)
      begin
        cnt <= (lnk.tmr_count == '0) ? '0 : lnk.tmr_count - rxs_pkg::WAIT_W'(1);
        run <= 1'b1;
      end
      else if (run)
      begin
        if (cnt == '0)
        begin
          run          <= 1'b0;
          lnk.tmr_done <= 1'b1;
        end
        else
        begin
          cnt <= cnt - rxs_pkg::WAIT_W'(1);
        end
      end
    end
  end
endmodule : rxs_wait_timer

// ---- rtl/rxs_seq_top.sv ----
// Overview of operation
// - after power-up the host runs the whole initialization list before using the transmitter
// - start with master reset, counter setup, ramp divider, calibration setup, 100 kHz divider
// - power up device and oscillator output, then wait 10 us
// - 50 MHz comparison, fraction low zero, divider 241.75, test pin high impedance
// - select 3.3 V levels and calibration-busy on the multiplexed output pin
// - set auxiliary converter clock to 1 MHz
// - program transmitter amplitude before calibration starts
// - start frequency calibration (init and recal words differ), then wait 1200 us
// - enable channel one only, trigger its amplitude calibration, wait 500 us
// - enable channel two only, trigger its amplitude calibration, wait 500 us
// - write step register for slots 0 to 3 with 144, 9, 144, 9
// - write deviation register for slots 0 to 3, alternating 455 and -7280
// - write clock divider register for slots 0 to 3, second divider 10
// - zero fraction low, integer 120 and fraction high 512 to lock
// - ramp-down on output pin, 3.3 V levels, wait 100 us, recal selects ramp mode
// - rerun recalibration after each 10 degree temperature change
// - recalibrate only once initialization is complete and device powered
// - recal turns both channels and oscillator off, then rewrites calibration setup
// - low five bits of each word select the destination register
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module rxs_seq_top #(
  parameter int SER_HALF     = rxs_pkg::SER_HALF_CYC,
  parameter int WAIT_LE_CYC  = rxs_pkg::CYC_LE,
  parameter int WAIT_VCO_CYC = rxs_pkg::CYC_VCO,
  parameter int WAIT_AMP_CYC = rxs_pkg::CYC_AMP,
  parameter int WAIT_LOCK_CYC = rxs_pkg::CYC_LOCK
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  output logic             SPI_CLK_O,
  output logic             SPI_DATA_O,
  output logic             SPI_LE_O
);

  rxs_link_if lnk ();

  rxs_ser_shift #(
    .HALF    (SER_HALF)
  ) u_ser (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .lnk     (lnk.ser),
    .sclk_o  (SPI_CLK_O),
    .sdata_o (SPI_DATA_O),
    .le_o    (SPI_LE_O)
  );

  rxs_wait_timer u_tmr (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .lnk     (lnk.tmr)
  );

  // entry = {wait code, last flag, word}; register number sits in the word's low five bits
  function automatic logic [35:0] rom(input logic [6:0] idx);
    logic [35:0] e;
    e = {rxs_pkg::W_NONE, 1'b1, 32'h00000000};
    case (idx)
      7'h00: e = {rxs_pkg::W_NONE, 1'b0, 32'h02000007};
      7'h01: e = {rxs_pkg::W_NONE, 1'b0, 32'h0000002B};
      7'h02: e = {rxs_pkg::W_NONE, 1'b0, 32'h0000000B};
      7'h03: e = {rxs_pkg::W_NONE, 1'b0, 32'h0018000D};
      7'h04: e = {rxs_pkg::W_NONE, 1'b0, 32'h1D32A64A};
      7'h05: e = {rxs_pkg::W_NONE, 1'b0, 32'h2A20B929};
      7'h06: e = {rxs_pkg::W_NONE, 1'b0, 32'h40003E88};
      7'h07: e = {rxs_pkg::W_LE,   1'b0, 32'h800FE520};
      7'h08: e = {rxs_pkg::W_NONE, 1'b0, 32'h01800827};
      7'h09: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000006};
      7'h0A: e = {rxs_pkg::W_NONE, 1'b0, 32'h01E38005};
      7'h0B: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000004};
      7'h0C: e = {rxs_pkg::W_NONE, 1'b0, 32'h01897803};
      7'h0D: e = {rxs_pkg::W_NONE, 1'b0, 32'h00020642};
      7'h0E: e = {rxs_pkg::W_NONE, 1'b0, 32'hFFF7FFE1};
      7'h0F: e = {rxs_pkg::W_VCO,  1'b0, 32'h800FE720};
      7'h10: e = {rxs_pkg::W_NONE, 1'b0, 32'h800FE560};
      7'h11: e = {rxs_pkg::W_AMP,  1'b0, 32'h800FED60};
      7'h12: e = {rxs_pkg::W_NONE, 1'b0, 32'h800FE5A0};
      7'h13: e = {rxs_pkg::W_AMP,  1'b0, 32'h800FF5A0};
      7'h14: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000011};
      7'h15: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000010};
      7'h16: e = {rxs_pkg::W_NONE, 1'b0, 32'h0000120F};
      7'h17: e = {rxs_pkg::W_NONE, 1'b0, 32'h0200012F};
      7'h18: e = {rxs_pkg::W_NONE, 1'b0, 32'h0400120F};
      7'h19: e = {rxs_pkg::W_NONE, 1'b0, 32'h0600012F};
      7'h1A: e = {rxs_pkg::W_NONE, 1'b0, 32'h012038EE};
      7'h1B: e = {rxs_pkg::W_NONE, 1'b0, 32'h033C720E};
      7'h1C: e = {rxs_pkg::W_NONE, 1'b0, 32'h052038EE};
      7'h1D: e = {rxs_pkg::W_NONE, 1'b0, 32'h073C720E};
      7'h1E: e = {rxs_pkg::W_NONE, 1'b0, 32'h0018050D};
      7'h1F: e = {rxs_pkg::W_NONE, 1'b0, 32'h0018052D};
      7'h20: e = {rxs_pkg::W_NONE, 1'b0, 32'h0018054D};
      7'h21: e = {rxs_pkg::W_NONE, 1'b0, 32'h0018056D};
      7'h22: e = {rxs_pkg::W_NONE, 1'b0, 32'h004F000C};
      7'h23: e = {rxs_pkg::W_NONE, 1'b0, 32'h2800B929};
      7'h24: e = {rxs_pkg::W_NONE, 1'b0, 32'h0100A027};
      7'h25: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000006};
      7'h26: e = {rxs_pkg::W_NONE, 1'b0, 32'h00F04005};
      7'h27: e = {rxs_pkg::W_NONE, 1'b0, 32'h00002004};
      7'h28: e = {rxs_pkg::W_LOCK, 1'b1, 32'h0189F803};
      7'h29: e = {rxs_pkg::W_NONE, 1'b0, 32'h800FE500};
      7'h2A: e = {rxs_pkg::W_NONE, 1'b0, 32'h2A20B929};
      7'h2B: e = {rxs_pkg::W_NONE, 1'b0, 32'h01800827};
      7'h2C: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000006};
      7'h2D: e = {rxs_pkg::W_NONE, 1'b0, 32'h01E38005};
      7'h2E: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000004};
      7'h2F: e = {rxs_pkg::W_NONE, 1'b0, 32'h01897803};
      7'h30: e = {rxs_pkg::W_NONE, 1'b0, 32'h00020642};
      7'h31: e = {rxs_pkg::W_NONE, 1'b0, 32'hFFF7FFE1};
      7'h32: e = {rxs_pkg::W_VCO,  1'b0, 32'h800FE700};
      7'h33: e = {rxs_pkg::W_NONE, 1'b0, 32'h800FE560};
      7'h34: e = {rxs_pkg::W_AMP,  1'b0, 32'h800FED60};
      7'h35: e = {rxs_pkg::W_NONE, 1'b0, 32'h800FE5A0};
      7'h36: e = {rxs_pkg::W_AMP,  1'b0, 32'h800FF5A0};
      7'h37: e = {rxs_pkg::W_NONE, 1'b0, 32'h2800B929};
      7'h38: e = {rxs_pkg::W_NONE, 1'b0, 32'h0100A027};
      7'h39: e = {rxs_pkg::W_NONE, 1'b0, 32'h00000006};
      7'h3A: e = {rxs_pkg::W_NONE, 1'b0, 32'h00F04005};
      7'h3B: e = {rxs_pkg::W_NONE, 1'b0, 32'h00002004};
      7'h3C: e = {rxs_pkg::W_LOCK, 1'b0, 32'h0189F803};
      7'h3D: e = {rxs_pkg::W_NONE, 1'b1, 32'h0000010B};
      default: e = {rxs_pkg::W_NONE, 1'b1, 32'h00000000};
    endcase
    return e;
  endfunction : rom

  rxs_pkg::rxs_seq_st_t st;
  logic [6:0]           idx;
  logic [35:0]          cur;
  logic [2:0]           cur_wait;
  logic                 cur_last;
  logic                 init_done;
  logic                 in_recal;
  logic                 pending;
  logic                 auto_en;
  logic [7:0]           temp_now;
  logic [7:0]           temp_ref;
  logic [15:0]          recal_cnt;
  logic                 wr_ctrl;
  logic                 init_go;
  logic                 recal_go;
  logic                 start_init;
  logic                 start_recal;
  logic                 idle;
  logic signed [8:0]    temp_diff;
  logic                 temp_moved;
  logic                 set_pend;

  assign cur      = rom(idx);
  assign cur_wait = cur[35:33];
  assign cur_last = cur[32];
  assign idle     = (st == rxs_pkg::SQ_IDLE);

  assign wr_ctrl  = WR_I && (ADDR_I == rxs_pkg::ADDR_CTRL);
  assign init_go  = wr_ctrl && WDATA_I[rxs_pkg::CTRL_INIT_GO];
  assign recal_go = wr_ctrl && WDATA_I[rxs_pkg::CTRL_RECAL_GO];

  assign temp_diff  = $signed({temp_now[7], temp_now}) - $signed({temp_ref[7], temp_ref});
  assign temp_moved = (temp_diff >= 9'(rxs_pkg::TEMP_DELTA_C)) || (temp_diff <= -9'(rxs_pkg::TEMP_DELTA_C));

  // recal requests before init completes are dropped, not queued
  assign set_pend    = init_done && (recal_go || (auto_en && temp_moved && !pending && !in_recal));
  assign start_init  = idle && init_go;
  assign start_recal = idle && !init_go && pending && init_done;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      pending <= 1'b0;
    end
    else if (set_pend)
    begin
      pending <= 1'b1;
    end
    else if (start_recal || !init_done)
    begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      auto_en  <= rxs_pkg::CTRL_AUTO_RST;
      temp_now <= 8'h00;
    end
    else if (WR_I)
    begin
      if (ADDR_I == rxs_pkg::ADDR_CTRL)
        auto_en <= WDATA_I[rxs_pkg::CTRL_AUTO_EN];
      if (ADDR_I == rxs_pkg::ADDR_TEMP)
        temp_now <= WDATA_I[7:0];
    end
  end

  // sequence engine: one serial write per entry, wait timed from the end of that write
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st            <= rxs_pkg::SQ_IDLE;
      idx           <= rxs_pkg::INIT_FIRST;
      init_done     <= 1'b0;
      in_recal      <= 1'b0;
      temp_ref      <= 8'h00;
      recal_cnt     <= 16'h0000;
      lnk.spi_start <= 1'b0;
      lnk.spi_word  <= 32'h00000000;
      lnk.tmr_start <= 1'b0;
      lnk.tmr_count <= '0;
    end
    else
    begin
      lnk.spi_start <= 1'b0;
      lnk.tmr_start <= 1'b0;
      case (st)
        rxs_pkg::SQ_IDLE:
        begin
          if (start_init)
          begin
            idx       <= rxs_pkg::INIT_FIRST;
            init_done <= 1'b0;
            in_recal  <= 1'b0;
            temp_ref  <= temp_now;
            st        <= rxs_pkg::SQ_SEND;
          end
          else if (start_recal)
          begin
            idx       <= rxs_pkg::RECAL_FIRST;
            in_recal  <= 1'b1;
            temp_ref  <= temp_now;
            recal_cnt <= recal_cnt + 16'h0001;
            st        <= rxs_pkg::SQ_SEND;
          end
        end
        rxs_pkg::SQ_SEND:
        begin
          if (!lnk.spi_busy)
          begin
            lnk.spi_word  <= cur[31:0];
            lnk.spi_start <= 1'b1;
            st            <= rxs_pkg::SQ_XFER;
          end
        end
        rxs_pkg::SQ_XFER:
        begin
          if (lnk.spi_done)
          begin
            if (cur_wait != rxs_pkg::W_NONE)
            begin
              lnk.tmr_start <= 1'b1;
              case (cur_wait)
                rxs_pkg::W_LE:   lnk.tmr_count <= rxs_pkg::WAIT_W'(WAIT_LE_CYC);
                rxs_pkg::W_VCO:  lnk.tmr_count <= rxs_pkg::WAIT_W'(WAIT_VCO_CYC);
                rxs_pkg::W_AMP:  lnk.tmr_count <= rxs_pkg::WAIT_W'(WAIT_AMP_CYC);
                rxs_pkg::W_LOCK: lnk.tmr_count <= rxs_pkg::WAIT_W'(WAIT_LOCK_CYC);
                default:         lnk.tmr_count <= rxs_pkg::WAIT_W'(1);
              endcase
              st <= rxs_pkg::SQ_HOLD;
            end
            else if (cur_last)
            begin
              init_done <= 1'b1;
              in_recal  <= 1'b0;
              st        <= rxs_pkg::SQ_IDLE;
            end
            else
            begin
              idx <= idx + 7'h01;
              st  <= rxs_pkg::SQ_SEND;
            end
          end
        end
        rxs_pkg::SQ_HOLD:
        begin
          if (lnk.tmr_done)
          begin
            if (cur_last)
            begin
              init_done <= 1'b1;
              in_recal  <= 1'b0;
              st        <= rxs_pkg::SQ_IDLE;
            end
            else
            begin
              idx <= idx + 7'h01;
              st  <= rxs_pkg::SQ_SEND;
            end
          end
        end
        default:
        begin
          st <= rxs_pkg::SQ_IDLE;
        end
      endcase
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      RDATA_O <= 32'h00000000;
    end
    else if (RD_I)
    begin
      case (ADDR_I)
        rxs_pkg::ADDR_CTRL:   RDATA_O <= {29'h00000000, auto_en, 2'h0};
        rxs_pkg::ADDR_STATUS: RDATA_O <= {17'h00000, idx, 4'h0, pending, in_recal, init_done, !idle};
        rxs_pkg::ADDR_TEMP:   RDATA_O <= {16'h0000, temp_ref, temp_now};
        rxs_pkg::ADDR_COUNT:  RDATA_O <= {16'h0000, recal_cnt};
        default:              RDATA_O <= 32'h00000000;
      endcase
    end
    else
    begin
      RDATA_O <= 32'h00000000;
    end
  end

endmodule : rxs_seq_top

// ---- test/rxs_seq_assertions.sv ----
`timescale 1ns/1ns
module rxs_seq_assertions #(
  parameter int SER_HALF      = 5,
  parameter int WAIT_LE_CYC   = 1000,
  parameter int WAIT_VCO_CYC  = 120000,
  parameter int WAIT_AMP_CYC  = 50000,
  parameter int WAIT_LOCK_CYC = 10000
) (
  input wire logic        REF_CLK_I,
  input wire logic        RST_N_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        SPI_CLK_O,
  input wire logic        SPI_DATA_O,
  input wire logic        SPI_LE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic        c_q;
  logic        le_q;
  logic [31:0] sh;
  logic [7:0]  rises;
  logic [7:0]  le_hi;
  logic [7:0]  ck_hi;
  int          wcnt;

  function automatic int wait_of(input logic [31:0] w);
    case (w)
      32'h800FE520: return WAIT_LE_CYC;
      32'h800FE720, 32'h800FE700: return WAIT_VCO_CYC;
      32'h800FED60, 32'h800FF5A0: return WAIT_AMP_CYC;
      32'h0189F803: return WAIT_LOCK_CYC;
      default: return 0;
    endcase
  endfunction : wait_of

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      c_q   <= 1'b0;
      le_q  <= 1'b0;
      sh    <= 32'h0;
      rises <= 8'h0;
    end
    else
    begin
      c_q   <= SPI_CLK_O;
      le_q  <= SPI_LE_O;
      if (SPI_CLK_O && !c_q) sh <= {sh[30:0], SPI_DATA_O};
      if (SPI_LE_O) rises <= 8'h0;
      else if (SPI_CLK_O && !c_q) rises <= rises + 8'h1;
    end

  // high-phase lengths, reset to 0 on the low phase
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      le_hi <= 8'h0;
      ck_hi <= 8'h0;
    end
    else
    begin
      le_hi <= SPI_LE_O ? le_hi + 8'h1 : 8'h0;
      ck_hi <= SPI_CLK_O ? ck_hi + 8'h1 : 8'h0;
    end

  // wait countdown armed at the end of each load pulse
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    if (!RST_N_I) wcnt <= 0;
    else if (!SPI_LE_O && le_q) wcnt <= wait_of(sh);
    else if (wcnt != 0) wcnt <= wcnt - 1;

  a_le_after_32: assert property ($rose(SPI_LE_O) |-> rises == 8'h20)
    else $error("load pulse not after 32 clock rises");
  a_le_width: assert property ($fell(SPI_LE_O) |-> le_hi == 8'(SER_HALF))
    else $error("load pulse width wrong");
  a_clk_high_len: assert property ($fell(SPI_CLK_O) |-> ck_hi == 8'(SER_HALF))
    else $error("serial clock high phase wrong");
  a_data_stable: assert property (SPI_CLK_O && $past(SPI_CLK_O) |-> $stable(SPI_DATA_O))
    else $error("serial data moved while clock high");
  a_le_clk_low: assert property (SPI_LE_O |-> !SPI_CLK_O && !$rose(SPI_CLK_O))
    else $error("clock active during load pulse");
  a_wait_kept: assert property ($rose(SPI_CLK_O) |-> wcnt == 0)
    else $error("word started before its wait ran out");
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property ($past(RD_I) && ($past(ADDR_I) & 8'hF3) != 8'h0 |-> RDATA_O == 32'h0)
    else $error("unmapped read not zero");

  c_word: cover property ($rose(SPI_LE_O));
  c_recal_cal: cover property ($fell(SPI_LE_O) && sh == 32'h800FE700);
  c_read: cover property ($past(RD_I) && RDATA_O != 32'h0);
endmodule : rxs_seq_assertions

bind rxs_seq_top rxs_seq_assertions #(.SER_HALF(SER_HALF), .WAIT_LE_CYC(WAIT_LE_CYC), .WAIT_VCO_CYC(WAIT_VCO_CYC),
  .WAIT_AMP_CYC(WAIT_AMP_CYC), .WAIT_LOCK_CYC(WAIT_LOCK_CYC)) u_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SPI_CLK_O(SPI_CLK_O),
  .SPI_DATA_O(SPI_DATA_O), .SPI_LE_O(SPI_LE_O));

// ---- test/rxs_dev_model.sv ----
`timescale 1ns/1ns
module rxs_dev_model (
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic le_i
);
  logic [31:0] sh;
  logic [31:0] regs [32];
  logic [31:0] words [$];
  int          gaps [$];
  longint      last_fall = 0;
  bit          first = 1'b1;

  // gap in 10 ns cycles from previous load end to first clock rise
  always @(posedge sclk_i)
  begin
    if (first) gaps.push_back(int'((($time) - last_fall) / 10));
    first = 1'b0;
    sh = {sh[30:0], sdata_i};
  end
  // word latched into the register its low five bits name
  always @(posedge le_i)
  begin
    words.push_back(sh);
    regs[sh[4:0]] = sh;
  end
  always @(negedge le_i)
  begin
    last_fall = $time;
    first = 1'b1;
  end
endmodule : rxs_dev_model

// ---- test/tb_radar_tx_init_recal_sequencer.sv ----
`timescale 1ns/1ns
module tb_radar_tx_init_recal_sequencer;
  localparam int WL = 20, WV = 40, WA = 30, WK = 25;
  logic        clk, rst_n, wr, rd, sclk, sdata, le;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  int          n_errors = 0, n_compared = 0, base, dlt;
  logic [31:0] init_w [$] = '{32'h02000007, 32'h0000002B, 32'h0000000B, 32'h0018000D, 32'h1D32A64A,
    32'h2A20B929, 32'h40003E88, 32'h800FE520, 32'h01800827, 32'h00000006, 32'h01E38005, 32'h00000004,
    32'h01897803, 32'h00020642, 32'hFFF7FFE1, 32'h800FE720, 32'h800FE560, 32'h800FED60, 32'h800FE5A0,
    32'h800FF5A0, 32'h00000011, 32'h00000010, 32'h0000120F, 32'h0200012F, 32'h0400120F, 32'h0600012F,
    32'h012038EE, 32'h033C720E, 32'h052038EE, 32'h073C720E, 32'h0018050D, 32'h0018052D, 32'h0018054D,
    32'h0018056D, 32'h004F000C, 32'h2800B929, 32'h0100A027, 32'h00000006, 32'h00F04005, 32'h00002004,
    32'h0189F803};
  logic [31:0] recal_w [$] = '{32'h800FE500, 32'h2A20B929, 32'h01800827, 32'h00000006, 32'h01E38005,
    32'h00000004, 32'h01897803, 32'h00020642, 32'hFFF7FFE1, 32'h800FE700, 32'h800FE560, 32'h800FED60,
    32'h800FE5A0, 32'h800FF5A0, 32'h2800B929, 32'h0100A027, 32'h00000006, 32'h00F04005, 32'h00002004,
    32'h0189F803, 32'h0000010B};

  rxs_seq_top #(.SER_HALF(2), .WAIT_LE_CYC(WL), .WAIT_VCO_CYC(WV), .WAIT_AMP_CYC(WA), .WAIT_LOCK_CYC(WK)) uut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SPI_CLK_O(sclk), .SPI_DATA_O(sdata), .SPI_LE_O(le));
  rxs_dev_model dev (.sclk_i(sclk), .sdata_i(sdata), .le_i(le));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  // minimum idle cycles the word w must be followed by; 0 means back to back
  function automatic int wait_after(input logic [31:0] w);
    case (w)
      32'h800FE520: return WL;
      32'h800FE720, 32'h800FE700: return WV;
      32'h800FED60, 32'h800FF5A0: return WA;
      32'h0189F803: return WK;
      default: return 0;
    endcase
  endfunction : wait_after

  task automatic expect_seq(input logic [31:0] tbl [$]);
    int w;
    for (int k = 0; k < 20000 && dev.words.size() < tbl.size(); k++) @(posedge clk);
    repeat (400) @(posedge clk);
    chk(32'(dev.words.size()), 32'(tbl.size()), "word count");
    foreach (tbl[i])
    begin
      chk(dev.words[i], tbl[i], "word");
      w = wait_after(tbl[i > 0 ? i - 1 : 0]);
      if (i > 0) chk({31'h0, (w > 0) ? dev.gaps[i] >= w : dev.gaps[i] < 15}, 32'h1, "gap");
    end
    dev.words.delete();
    dev.gaps.delete();
  endtask : expect_seq

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial
  begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    void'($urandom(7));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 16; a += 4)
    begin
      rd_reg(8'(a), d);
      chk(d, 32'h0, "reset read");
    end
    wr_reg(8'h00, 32'h2);
    repeat (200) @(posedge clk);
    chk(32'(dev.words.size()), 32'h0, "recal before init");
    $display("test reset and early recal done");
    wr_reg(8'h00, 32'h1);
    repeat (40) @(posedge clk);
    wr_reg(8'h00, 32'h1);
    expect_seq(init_w);
    rd_reg(8'h04, d);
    chk(d & 32'h3, 32'h2, "init done");
    $display("test init done");
    base = int'($urandom_range(40)) - 20;
    wr_reg(8'h08, 32'(base) & 32'hFF);
    wr_reg(8'h00, 32'h2);
    expect_seq(recal_w);
    rd_reg(8'h0C, d);
    chk(d & 32'hFFFF, 32'h1, "recal count");
    $display("test manual recal done");
    dlt = ($urandom % 2) ? 9 : -9;
    wr_reg(8'h00, 32'h4);
    wr_reg(8'h08, 32'(base + dlt) & 32'hFF);
    repeat (300) @(posedge clk);
    chk(32'(dev.words.size()), 32'h0, "no recal under 10 degrees");
    wr_reg(8'h08, 32'(base + (dlt > 0 ? 10 : -10)) & 32'hFF);
    expect_seq(recal_w);
    rd_reg(8'h0C, d);
    chk(d & 32'hFFFF, 32'h2, "auto recal count");
    rd_reg(8'h00, d);
    chk(d, 32'h4, "auto enable readback");
    rd_reg(8'h08, d);
    chk(d, {16'h0000, 8'(base + (dlt > 0 ? 10 : -10)), 8'(base + (dlt > 0 ? 10 : -10))}, "temp regs");
    $display("test auto recal done");
    conclude();
  end
endmodule : tb_radar_tx_init_recal_sequencer
